// *** pdm_top.sv ***
// Peripheral DMA channel pair between a serial peripheral and the bus matrix
// Contract
// - Receive ready: request bus, read holding register, buffer it, write memory.
// - Transmit ready: request bus, fetch from memory, write transmit holding register.
// - Channel flags reach software only through the peripheral's status register.
// - Half duplex shares one channel's flags; full duplex uses two channels.
// - Receive end sets at zero after last write; cleared by nonzero receive counts.
// - Transmit end sets at zero after last put; cleared by nonzero transmit counts in full duplex, by receive counts in half duplex.
// - Receive full sets when both receive counts are zero; cleared by transmit counts in full duplex, by receive counts in half duplex.
// - Transmit empty sets when both transmit counts are zero; cleared by transmit counts in full duplex, by receive counts in half duplex.
`timescale 1ns/1ps
`default_nettype none
`include "pdm_defines.svh"

module pdm_top (
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    // Register port
    input  wire logic [`PDM_ADDR_W-1:0] reg_addr_i,
    input  wire logic [`PDM_DATA_W-1:0] reg_wdata_i,
    input  wire logic                   reg_we_i,
    input  wire logic                   reg_re_i,
    output logic      [`PDM_DATA_W-1:0] reg_rdata_o,
    // Peripheral control
    input  wire logic                   half_duplex_i,
    input  wire logic                   rx_channel_enable_i,
    input  wire logic                   tx_channel_enable_i,
    // Peripheral receive side
    input  wire logic                   rx_ready_i,
    input  wire logic [`PDM_DATA_W-1:0] receive_holding_reg_i,
    output logic                        rx_read_o,
    // Peripheral transmit side
    input  wire logic                   tx_ready_i,
    output logic      [`PDM_DATA_W-1:0] transmit_holding_reg_o,
    output logic                        tx_write_o,
    // Flags to the peripheral status register
    output logic                        rx_transfer_end_flag_o,
    output logic                        rx_buffer_full_flag_o,
    output logic                        tx_transfer_end_flag_o,
    output logic                        tx_buffer_empty_flag_o,
    // Bus matrix master
    output logic                        bus_req_o,
    output logic                        bus_we_o,
    output logic      [`PDM_DATA_W-1:0] bus_addr_o,
    output logic      [`PDM_DATA_W-1:0] bus_wdata_o,
    input  wire logic                   bus_gnt_i,
    input  wire logic [`PDM_DATA_W-1:0] bus_rdata_i
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    pdm_pkg::pdm_chan_t     ch0;
    pdm_pkg::pdm_chan_t     ch1;
    pdm_pkg::pdm_chan_t     tx_st;
    pdm_pkg::pdm_field_t    wr_field;
    logic                   wr_hit;
    logic                   wr_tx;
    logic                   rx_cnt_nz;
    logic                   tx_cnt_nz;
    logic                   clr0_end;
    logic                   clr0_buf;
    logic                   done0;
    logic                   done1;
    logic                   rx_go;
    logic                   tx_go;

    pdm_pkg::pdm_state_t    state_q;
    pdm_pkg::pdm_state_t    state_d;
    pdm_pkg::pdm_bus_t      bus_q;
    pdm_pkg::pdm_bus_t      bus_d;
    logic                   rx_read_q;
    logic                   rx_read_d;
    logic                   tx_write_q;
    logic                   tx_write_d;
    logic [`PDM_DATA_W-1:0] thr_q;
    logic [`PDM_DATA_W-1:0] thr_d;

    logic [3:0]             flags_q;
    logic [3:0]             flags_d;
    logic [`PDM_DATA_W-1:0] rdata_q;
    logic [`PDM_DATA_W-1:0] rdata_d;

    // ------------------------------------------------------------------
    // Register write decode
    // ------------------------------------------------------------------
    always_comb begin
        wr_hit   = reg_we_i;
        wr_tx    = 1'b0;
        wr_field = pdm_pkg::PDM_F_PTR;
        unique case (reg_addr_i)
            `PDM_RX_PTR:  wr_field = pdm_pkg::PDM_F_PTR;
            `PDM_RX_CNT:  wr_field = pdm_pkg::PDM_F_CNT;
            `PDM_RX_NPTR: wr_field = pdm_pkg::PDM_F_NPTR;
            `PDM_RX_NCNT: wr_field = pdm_pkg::PDM_F_NCNT;
            `PDM_TX_PTR: begin
                wr_tx    = 1'b1;
                wr_field = pdm_pkg::PDM_F_PTR;
            end
            `PDM_TX_CNT: begin
                wr_tx    = 1'b1;
                wr_field = pdm_pkg::PDM_F_CNT;
            end
            `PDM_TX_NPTR: begin
                wr_tx    = 1'b1;
                wr_field = pdm_pkg::PDM_F_NPTR;
            end
            `PDM_TX_NCNT: begin
                wr_tx    = 1'b1;
                wr_field = pdm_pkg::PDM_F_NCNT;
            end
            default: wr_hit = 1'b0;
        endcase
    end

    // Nonzero writes to either counter of a direction clear its flags, except receive full, cleared by transmit counts in full duplex
    always_comb begin
        rx_cnt_nz = wr_hit && !wr_tx
                 && (wr_field == pdm_pkg::PDM_F_CNT || wr_field == pdm_pkg::PDM_F_NCNT)
                 && reg_wdata_i[`PDM_CNT_W-1:0] != `PDM_CNT_ZERO;
        tx_cnt_nz = wr_hit && wr_tx
                 && (wr_field == pdm_pkg::PDM_F_CNT || wr_field == pdm_pkg::PDM_F_NCNT)
                 && reg_wdata_i[`PDM_CNT_W-1:0] != `PDM_CNT_ZERO;
        clr0_end  = rx_cnt_nz;
        // Receive full follows the transmit counters in full duplex
        clr0_buf  = half_duplex_i ? rx_cnt_nz : tx_cnt_nz;
    end

    // ------------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------------
    pdm_chan u_rx_chan (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .wr_i      (wr_hit && !wr_tx),
        .field_i   (wr_field),
        .wdata_i   (reg_wdata_i),
        .done_i    (done0),
        .clr_end_i (clr0_end),
        .clr_buf_i (clr0_buf),
        .st_o      (ch0)
    );

    pdm_chan u_tx_chan (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .wr_i      (wr_hit && wr_tx),
        .field_i   (wr_field),
        .wdata_i   (reg_wdata_i),
        .done_i    (done1),
        .clr_end_i (tx_cnt_nz),
        .clr_buf_i (tx_cnt_nz),
        .st_o      (ch1)
    );

    // Half duplex runs both directions on the receive channel
    assign tx_st = half_duplex_i ? ch0 : ch1;

    // ------------------------------------------------------------------
    // Transfer sequencer
    // ------------------------------------------------------------------
    always_comb begin
        rx_go = rx_ready_i && rx_channel_enable_i
             && ch0.cnt != `PDM_CNT_ZERO
             && !(half_duplex_i && tx_channel_enable_i);
        tx_go = tx_ready_i && tx_channel_enable_i
             && tx_st.cnt != `PDM_CNT_ZERO;
    end

    always_comb begin
        state_d    = state_q;
        bus_d      = bus_q;
        rx_read_d  = 1'b0;
        tx_write_d = 1'b0;
        thr_d      = thr_q;
        done0      = 1'b0;
        done1      = 1'b0;
        unique case (state_q)
            pdm_pkg::PDM_ST_IDLE: begin
                // Receive first: an unread holding register overruns sooner
                if (rx_go) begin
                    rx_read_d   = 1'b1;
                    bus_d.req   = 1'b1;
                    bus_d.we    = 1'b1;
                    bus_d.addr  = ch0.ptr;
                    bus_d.wdata = receive_holding_reg_i;
                    state_d     = pdm_pkg::PDM_ST_RX_REQ;
                end else if (tx_go) begin
                    bus_d.req   = 1'b1;
                    bus_d.we    = 1'b0;
                    bus_d.addr  = tx_st.ptr;
                    bus_d.wdata = `PDM_DATA_ZERO;
                    state_d     = pdm_pkg::PDM_ST_TX_REQ;
                end
            end
            pdm_pkg::PDM_ST_RX_REQ: begin
                if (bus_gnt_i) begin
                    bus_d.req = 1'b0;
                    bus_d.we  = 1'b0;
                    done0     = 1'b1;
                    state_d   = pdm_pkg::PDM_ST_IDLE;
                end
            end
            pdm_pkg::PDM_ST_TX_REQ: begin
                if (bus_gnt_i) begin
                    bus_d.req  = 1'b0;
                    thr_d      = bus_rdata_i;
                    tx_write_d = 1'b1;
                    state_d    = pdm_pkg::PDM_ST_TX_PUT;
                end
            end
            pdm_pkg::PDM_ST_TX_PUT: begin
                // Count the item once it stands in the holding register
                done0   = half_duplex_i;
                done1   = !half_duplex_i;
                state_d = pdm_pkg::PDM_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q    <= pdm_pkg::PDM_ST_IDLE;
            bus_q      <= '0;
            rx_read_q  <= 1'b0;
            tx_write_q <= 1'b0;
            thr_q      <= `PDM_DATA_ZERO;
        end else begin
            state_q    <= state_d;
            bus_q      <= bus_d;
            rx_read_q  <= rx_read_d;
            tx_write_q <= tx_write_d;
            thr_q      <= thr_d;
        end
    end

    // ------------------------------------------------------------------
    // Flags and register read-back
    // ------------------------------------------------------------------
    always_comb begin
        // Order: rx end, rx full, tx end, tx empty
        flags_d = {ch0.end_f, ch0.buf_f, tx_st.end_f, tx_st.buf_f};
        rdata_d = `PDM_DATA_ZERO;
        if (reg_re_i) begin
            unique case (reg_addr_i)
                `PDM_RX_PTR:  rdata_d = ch0.ptr;
                `PDM_RX_CNT:  rdata_d = {{(`PDM_DATA_W-`PDM_CNT_W){1'b0}}, ch0.cnt};
                `PDM_RX_NPTR: rdata_d = ch0.nptr;
                `PDM_RX_NCNT: rdata_d = {{(`PDM_DATA_W-`PDM_CNT_W){1'b0}}, ch0.ncnt};
                `PDM_TX_PTR:  rdata_d = ch1.ptr;
                `PDM_TX_CNT:  rdata_d = {{(`PDM_DATA_W-`PDM_CNT_W){1'b0}}, ch1.cnt};
                `PDM_TX_NPTR: rdata_d = ch1.nptr;
                `PDM_TX_NCNT: rdata_d = {{(`PDM_DATA_W-`PDM_CNT_W){1'b0}}, ch1.ncnt};
                default:      rdata_d = `PDM_DATA_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            flags_q <= 4'h0;
            rdata_q <= `PDM_DATA_ZERO;
        end else begin
            flags_q <= flags_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata_o            = rdata_q;
    assign rx_read_o              = rx_read_q;
    assign tx_write_o             = tx_write_q;
    assign transmit_holding_reg_o = thr_q;
    assign rx_transfer_end_flag_o = flags_q[3];
    assign rx_buffer_full_flag_o  = flags_q[2];
    assign tx_transfer_end_flag_o = flags_q[1];
    assign tx_buffer_empty_flag_o = flags_q[0];
    assign bus_req_o              = bus_q.req;
    assign bus_we_o               = bus_q.we;
    assign bus_addr_o             = bus_q.addr;
    assign bus_wdata_o            = bus_q.wdata;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_rx_read_req: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rx_read_o |-> bus_req_o && bus_we_o && bus_wdata_o == $past(receive_holding_reg_i))
        else $error("receive read without buffered memory write");

    a_bus_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        bus_req_o && !bus_gnt_i |=> bus_req_o && $stable(bus_addr_o) && $stable(bus_we_o))
        else $error("bus request dropped or changed before grant");

    a_tx_put: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        bus_req_o && !bus_we_o && bus_gnt_i |=> tx_write_o && !bus_req_o
        && transmit_holding_reg_o == $past(bus_rdata_i))
        else $error("fetched word not put in transmit holding register");

    a_half_flags: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        half_duplex_i && $past(half_duplex_i) |-> tx_transfer_end_flag_o == rx_transfer_end_flag_o
        && tx_buffer_empty_flag_o == rx_buffer_full_flag_o)
        else $error("half duplex flags not shared");

    a_rx_end_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        done0 && ch0.cnt == `PDM_CNT_ONE |-> ##2 rx_transfer_end_flag_o)
        else $error("receive end flag missing");

    a_rx_end_clr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rx_cnt_nz && !done0 |-> ##2 !rx_transfer_end_flag_o)
        else $error("receive end flag not cleared");

    a_rx_full_clr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !half_duplex_i ##1 (!half_duplex_i && tx_cnt_nz && !done0) |-> ##2 !rx_buffer_full_flag_o)
        else $error("receive full flag not cleared by transmit count");

    a_tx_empty_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !half_duplex_i ##1 (!half_duplex_i && done1 && ch1.cnt == `PDM_CNT_ONE
        && ch1.ncnt == `PDM_CNT_ZERO) ##1 !half_duplex_i |-> ##1 tx_buffer_empty_flag_o)
        else $error("transmit empty flag missing");

endmodule : pdm_top
`default_nettype wire

// *** pdm_defines.svh ***
// Named constants for the peripheral DMA channel pair
`ifndef PDM_DEFINES_SVH
`define PDM_DEFINES_SVH

// ----------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------
`define PDM_ADDR_W      8
`define PDM_RX_PTR      8'h00
`define PDM_RX_CNT      8'h04
`define PDM_TX_PTR      8'h08
`define PDM_TX_CNT      8'h0c
`define PDM_RX_NPTR     8'h10
`define PDM_RX_NCNT     8'h14
`define PDM_TX_NPTR     8'h18
`define PDM_TX_NCNT     8'h1c

// ----------------------------------------------------------------------
// Widths, reset values and steps
// ----------------------------------------------------------------------
`define PDM_DATA_W      32
`define PDM_CNT_W       16
`define PDM_CNT_ZERO    16'h0000
`define PDM_CNT_ONE     16'h0001
`define PDM_PTR_ZERO    32'h00000000
`define PDM_DATA_ZERO   32'h00000000
`define PDM_STEP        32'h00000004

`endif

// *** pdm_pkg.sv ***
// Types shared by the peripheral DMA channel pair
`default_nettype none
`include "pdm_defines.svh"

package pdm_pkg;

    // ------------------------------------------------------------------
    // Register field of one channel
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PDM_F_PTR  = 2'h0,
        PDM_F_CNT  = 2'h1,
        PDM_F_NPTR = 2'h2,
        PDM_F_NCNT = 2'h3
    } pdm_field_t;

    // ------------------------------------------------------------------
    // Channel state and bus request
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [`PDM_DATA_W-1:0] ptr;
        logic [`PDM_CNT_W-1:0]  cnt;
        logic [`PDM_DATA_W-1:0] nptr;
        logic [`PDM_CNT_W-1:0]  ncnt;
        logic                   end_f;
        logic                   buf_f;
    } pdm_chan_t;

    typedef struct packed {
        logic                   req;
        logic                   we;
        logic [`PDM_DATA_W-1:0] addr;
        logic [`PDM_DATA_W-1:0] wdata;
    } pdm_bus_t;

    typedef enum logic [3:0] {
        PDM_ST_IDLE   = 4'h1,
        PDM_ST_RX_REQ = 4'h2,
        PDM_ST_TX_REQ = 4'h4,
        PDM_ST_TX_PUT = 4'h8
    } pdm_state_t;

endpackage : pdm_pkg
`default_nettype wire

// *** pdm_chan.sv ***
// One DMA channel: pointers, counters, reload and flags
`timescale 1ns/1ps
`default_nettype none
`include "pdm_defines.svh"

module pdm_chan (
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    // Software write
    input  wire logic                   wr_i,
    input  wire pdm_pkg::pdm_field_t    field_i,
    input  wire logic [`PDM_DATA_W-1:0] wdata_i,
    // Transfer and flag control
    input  wire logic                   done_i,
    input  wire logic                   clr_end_i,
    input  wire logic                   clr_buf_i,
    // State
    output pdm_pkg::pdm_chan_t          st_o
);

    pdm_pkg::pdm_chan_t st_q;
    pdm_pkg::pdm_chan_t st_d;
    logic               set_end;
    logic               set_buf;

    always_comb begin
        st_d    = st_q;
        set_end = 1'b0;
        set_buf = 1'b0;
        if (done_i) begin
            st_d.ptr = st_q.ptr + `PDM_STEP;
            st_d.cnt = st_q.cnt - `PDM_CNT_ONE;
            if (st_q.cnt == `PDM_CNT_ONE) begin
                set_end = 1'b1;
                if (st_q.ncnt == `PDM_CNT_ZERO) begin
                    set_buf = 1'b1;
                end else begin
                    st_d.ptr  = st_q.nptr;
                    st_d.cnt  = st_q.ncnt;
                    st_d.ncnt = `PDM_CNT_ZERO;
                end
            end
        end else if (st_q.cnt == `PDM_CNT_ZERO && st_q.ncnt != `PDM_CNT_ZERO) begin
            // Next pair programmed while idle at zero: take it over
            st_d.ptr  = st_q.nptr;
            st_d.cnt  = st_q.ncnt;
            st_d.ncnt = `PDM_CNT_ZERO;
        end
        // Software write overrides the hardware update of its field
        if (wr_i) begin
            unique case (field_i)
                pdm_pkg::PDM_F_PTR:  st_d.ptr  = wdata_i;
                pdm_pkg::PDM_F_CNT:  st_d.cnt  = wdata_i[`PDM_CNT_W-1:0];
                pdm_pkg::PDM_F_NPTR: st_d.nptr = wdata_i;
                pdm_pkg::PDM_F_NCNT: st_d.ncnt = wdata_i[`PDM_CNT_W-1:0];
            endcase
        end
        // Set wins over a clear in the same cycle
        st_d.end_f = set_end | (st_q.end_f & ~clr_end_i);
        st_d.buf_f = set_buf | (st_q.buf_f & ~clr_buf_i);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign st_o = st_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_cnt_step: assert property (done_i && !wr_i && st_q.cnt > `PDM_CNT_ONE |=>
        st_q.cnt == $past(st_q.cnt) - `PDM_CNT_ONE && st_q.ptr == $past(st_q.ptr) + `PDM_STEP)
        else $error("counter or pointer did not step");
    a_end_set: assert property (done_i && st_q.cnt == `PDM_CNT_ONE |=> st_q.end_f)
        else $error("end flag not set at zero");
    a_buf_set: assert property (done_i && st_q.cnt == `PDM_CNT_ONE &&
        st_q.ncnt == `PDM_CNT_ZERO |=> st_q.buf_f && st_q.cnt == `PDM_CNT_ZERO)
        else $error("buffer flag not set");
    a_next_reload: assert property (done_i && !wr_i && st_q.cnt == `PDM_CNT_ONE &&
        st_q.ncnt != `PDM_CNT_ZERO |=> st_q.cnt == $past(st_q.ncnt) &&
        st_q.ptr == $past(st_q.nptr) && st_q.ncnt == `PDM_CNT_ZERO && !st_q.buf_f)
        else $error("next pair not reloaded");

endmodule : pdm_chan
`default_nettype wire

// *** pdm_far.sv ***
// Bus matrix and memory model facing the DMA channel pair
`timescale 1ns/1ps
`default_nettype none

module pdm_far (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Master side
    input  wire logic        req_i,
    input  wire logic [1:0]  lat_i,
    input  wire logic [31:0] addr_i,
    output logic             gnt_o,
    output logic [31:0]      rdata_o
);
    logic [1:0]  wait_q;
    logic [31:0] spin_q;
    // Slow grants stretch the request; read data is junk outside the grant
    assign gnt_o   = req_i && (wait_q >= lat_i);
    assign rdata_o = gnt_o ? ~addr_i : spin_q;
    always_ff @(posedge clk_i) begin
        spin_q <= rst_n_i ? spin_q + 32'h9e3779b9 : 32'h5a5a5a5a;
        wait_q <= (!rst_n_i || !req_i || gnt_o) ? 2'h0 : wait_q + 2'h1;
    end
endmodule : pdm_far
`default_nettype wire

// *** tb.sv ***
// Self-checking testbench for the DMA channel pair
`timescale 1ns/1ps
`default_nettype none
`include "pdm_defines.svh"

module tb;
    logic        clk_i = 1'b0, rst_n_i = 1'b0, we_i = 1'b0, re_i = 1'b0, hd = 1'b0;
    logic        rx_en = 1'b1, tx_en = 1'b1, rx_rdy = 1'b0, tx_rdy = 1'b0, rx_rd, tx_wr;
    logic        rxe, rxf, txe, txb, req, we, gnt;
    logic [7:0]  addr = 8'h00;
    logic [1:0]  lat = 2'h0;
    logic [31:0] wdata = 32'h0, rdata, hold = 32'h0, transmit_holding_reg, baddr, bwd, grd, p, np, d;
    int          n_fail = 0, n_compared = 0, n_rd = 0;

    pdm_top i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_we_i(we_i), .reg_re_i(re_i), .reg_rdata_o(rdata), .half_duplex_i(hd),
        .rx_channel_enable_i(rx_en), .tx_channel_enable_i(tx_en), .rx_ready_i(rx_rdy),
        .receive_holding_reg_i(hold), .rx_read_o(rx_rd), .tx_ready_i(tx_rdy),
        .transmit_holding_reg_o(transmit_holding_reg), .tx_write_o(tx_wr), .rx_transfer_end_flag_o(rxe),
        .rx_buffer_full_flag_o(rxf), .tx_transfer_end_flag_o(txe),
        .tx_buffer_empty_flag_o(txb), .bus_req_o(req), .bus_we_o(we), .bus_addr_o(baddr),
        .bus_wdata_o(bwd), .bus_gnt_i(gnt), .bus_rdata_i(grd));
    pdm_far i_far (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req), .lat_i(lat),
        .addr_i(baddr), .gnt_o(gnt), .rdata_o(grd));

    initial forever #5 clk_i = ~clk_i;
    always @(negedge clk_i) if (rx_rd === 1'b1) n_rd++;

    task automatic finish_test();
        $display("Compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [31:0] nxt_ptr(input logic [31:0] a);
        return a + `PDM_STEP;
    endfunction : nxt_ptr
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        we_i <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        re_i <= 1'b1;
        addr <= a;
        @(posedge clk_i);
        re_i <= 1'b0;
        @(negedge clk_i);
        chk(rdata, e);
        // Read data stand one cycle only
        @(negedge clk_i);
        chk(rdata, 32'h0);
    endtask : rd
    // Wait for the granted cycle, bounded so a stuck request ends the run
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
        int i;
        for (i = 0; i < 12; i++) begin
            @(negedge clk_i);
            if (req && gnt) break;
        end
        if (i == 12) begin
            n_fail++;
            finish_test();
        end else begin
            chk({31'h0, we}, {31'h0, w});
            chk(baddr, a);
            if (w) chk(bwd, wd);
            @(posedge clk_i);
        end
    endtask : xfer
    // One-cycle ready pulse from idle, so a finished read is never retaken
    task automatic rx_item(input logic [31:0] a);
        d = $urandom;
        @(posedge clk_i);
        rx_rdy <= 1'b1;
        hold <= d;
        lat <= 2'($urandom % 3);
        @(posedge clk_i);
        rx_rdy <= 1'b0;
        hold <= ~d;
        xfer(1'b1, a, d);
    endtask : rx_item
    task automatic flags(input logic [3:0] e);
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        chk({28'h0, rxe, rxf, txe, txb}, {28'h0, e});
    endtask : flags

    initial begin
        d = $urandom(32'hdf2b34ed);
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        flags(4'h0);
        rd(8'h20, 32'h0);
        wr(`PDM_RX_CNT, 32'h2);
        rx_en <= 1'b0;
        @(posedge clk_i);
        rx_rdy <= 1'b1;
        repeat (3) @(posedge clk_i);
        rx_rdy <= 1'b0;
        chk(n_rd, 0);
        $display("Test disabled channel finished");
        p = {$urandom} & 32'hfffffffc;
        np = {$urandom} & 32'hfffffffc;
        wr(`PDM_RX_PTR, p);
        wr(`PDM_RX_NPTR, np);
        wr(`PDM_RX_NCNT, 32'h1);
        rx_en <= 1'b1;
        rx_item(p);
        rx_item(nxt_ptr(p));
        rd(`PDM_RX_CNT, 32'h1);
        rd(`PDM_RX_NCNT, 32'h0);
        rd(`PDM_RX_PTR, np);
        flags(4'h8);
        wr(`PDM_RX_CNT, 32'h1);
        flags(4'h0);
        rx_item(np);
        flags(4'hc);
        rd(`PDM_RX_PTR, nxt_ptr(np));
        chk(n_rd, 3);
        wr(`PDM_TX_CNT, 32'h1);
        flags(4'h8);
        $display("Test receive finished");
        p = {$urandom} & 32'hfffffffc;
        wr(`PDM_TX_PTR, p);
        rd(`PDM_TX_PTR, p);
        @(posedge clk_i);
        tx_rdy <= 1'b1;
        lat <= 2'h2;
        xfer(1'b0, p, 32'h0);
        @(negedge clk_i);
        chk({31'h0, tx_wr}, 32'h1);
        chk(transmit_holding_reg, ~p);
        @(posedge clk_i);
        tx_rdy <= 1'b0;
        flags(4'hb);
        rd(`PDM_TX_PTR, nxt_ptr(p));
        wr(`PDM_TX_NCNT, 32'h5);
        flags(4'h8);
        $display("Test transmit finished");
        @(posedge clk_i);
        hd <= 1'b1;
        flags(4'ha);
        chk({30'h0, txe, txb}, {30'h0, rxe, rxf});
        wr(`PDM_RX_CNT, 32'h1);
        flags(4'h0);
        // Shared channel: transmit runs on the receive register set
        @(posedge clk_i);
        tx_rdy <= 1'b1;
        xfer(1'b0, nxt_ptr(np), 32'h0);
        @(posedge clk_i);
        tx_rdy <= 1'b0;
        chk(transmit_holding_reg, ~nxt_ptr(np));
        flags(4'hf);
        $display("Test half duplex finished");
        finish_test();
    end
endmodule : tb
`default_nettype wire
